// file: scm_core.sv
// Execution core for the memory access and ALU opcodes of the stack machine.
`timescale 1ns/1ps

// Behaviour
// (RQ1) Fetch-advance pushes memory at address, increments address.
// (RQ2) Both fetches and literal clear the carry.
// (RQ3) Literal pushes next program word, skips it.
// (RQ4) Fetch-hold pushes memory at address, address kept.
// (RQ5) Write-advance pops top to memory, increments address.
// (RQ6) Write-hold pops top to memory, address kept.
// (RQ7) Byte-rotate turns top right eight bits.
// (RQ8) Drop-second pops deeper stack into second.
// (RQ9) Invert complements all top bits.
// (RQ10) Shift-left: bit 23 to carry, bit 0 cleared.
// (RQ11) Shift-right keeps sign, bit 0 to serial out.
// (RQ12) Shift-right samples serial input into carry.
// (RQ13) Multiply step: conditional add, pair shifts right.
// (RQ14) Twenty-four steps leave full product, second kept.
// (RQ15) XOR pops second into top.
// (RQ16) AND pops second into top.
// (RQ17) Divide step: keep carrying sum, pair shifts left.
// (RQ18) Four slots per word, high slot first.
// (RQ19) Carry is one bit beside the top.
// (RQ20) Push and pop ripple through second and stack.
module scm_core #(
	parameter int DATA_W = scm_pkg::DATA_W,
	parameter int STACK_DEPTH = scm_pkg::STACK_DEPTH
) (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic i_run,
	input wire logic i_ser_in,
	input wire logic i_mem_ack,
	input wire logic [23:0] i_mem_rdata,
	output logic o_mem_req,
	output logic o_mem_we,
	output logic [23:0] o_mem_addr,
	output logic [23:0] o_mem_wdata,
	output logic o_ser_out,
	output logic [23:0] o_top,
	output logic [23:0] o_second,
	output logic [23:0] o_addr,
	output logic [23:0] o_pc,
	output logic o_carry,
	output logic [3:0] o_depth
);

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	function automatic logic [5:0] slot_op(input logic [23:0] word,
		input logic [1:0] slot);
		logic [5:0] op;
		op = 6'h00;
		case (slot)
			2'h0: op = word[23:18];
			2'h1: op = word[17:12];
			2'h2: op = word[11:6];
			default: op = word[5:0];
		endcase
		return op;
	endfunction

	function automatic logic pops_at_exec(input logic [5:0] op);
		return (op == scm_pkg::OP_WRITE_ADVANCE) ||
			(op == scm_pkg::OP_WRITE_HOLD) ||
			(op == scm_pkg::OP_DROP_SECOND) ||
			(op == scm_pkg::OP_XOR) ||
			(op == scm_pkg::OP_AND);
	endfunction

	function automatic logic is_read(input logic [5:0] op);
		return (op == scm_pkg::OP_FETCH_ADVANCE) ||
			(op == scm_pkg::OP_FETCH_HOLD);
	endfunction

	function automatic logic is_write(input logic [5:0] op);
		return (op == scm_pkg::OP_WRITE_ADVANCE) ||
			(op == scm_pkg::OP_WRITE_HOLD);
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	scm_pkg::scm_state_type state_ff;
	scm_pkg::scm_state_type nxt_state;
	logic [23:0] instr_ff;
	logic [1:0] slot_ff;
	logic [23:0] top_ff;
	logic carry_ff;
	logic [23:0] second_ff;
	logic [23:0] addr_ff;
	logic [23:0] pc_ff;
	logic [23:0] stk_ff [STACK_DEPTH];
	logic [3:0] ptr_ff;
	logic [3:0] depth_ff;
	logic req_ff;
	logic we_ff;
	logic [23:0] maddr_ff;
	logic [23:0] wdata_ff;
	logic ser_out_ff;

	logic [5:0] cur_op;
	logic exec;
	logic rd_done;
	logic lit_done;
	logic push_en;
	logic pop_en;
	logic last_slot;
	logic [3:0] ptr_up;
	logic [24:0] mul_sum;
	logic [24:0] div_sum;
	logic [23:0] div_keep;

	assign cur_op = slot_op(instr_ff, slot_ff); // (RQ18)
	assign exec = (state_ff == scm_pkg::ST_EXEC);
	assign rd_done = (state_ff == scm_pkg::ST_WAIT_D) && i_mem_ack;
	assign lit_done = (state_ff == scm_pkg::ST_WAIT_LIT) && i_mem_ack;
	assign push_en = rd_done || lit_done;
	assign pop_en = exec && pops_at_exec(cur_op);
	assign last_slot = (slot_ff == scm_pkg::LAST_SLOT);
	assign ptr_up = (ptr_ff == scm_pkg::LAST_PTR) ? scm_pkg::RST_PTR :
		ptr_ff + 4'h1;

	// The pair steps need the adder's carry out, so the sums are one wider.
	assign mul_sum = {1'b0, top_ff} +
		(addr_ff[0] ? {1'b0, second_ff} : 25'h0000000); // (RQ13)
	assign div_sum = {1'b0, top_ff} + {1'b0, second_ff};
	assign div_keep = div_sum[24] ? div_sum[23:0] : top_ff; // (RQ17)

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			scm_pkg::ST_FETCH: begin
				if (i_run) begin
					nxt_state = scm_pkg::ST_WAIT_I;
				end
			end
			scm_pkg::ST_WAIT_I: begin
				if (i_mem_ack) begin
					nxt_state = scm_pkg::ST_EXEC;
				end
			end
			scm_pkg::ST_EXEC: begin
				if (is_read(cur_op)) begin
					nxt_state = scm_pkg::ST_WAIT_D;
				end else if (cur_op == scm_pkg::OP_LITERAL) begin
					nxt_state = scm_pkg::ST_WAIT_LIT;
				end else if (is_write(cur_op)) begin
					nxt_state = scm_pkg::ST_WAIT_W;
				end else if (last_slot) begin
					nxt_state = scm_pkg::ST_FETCH;
				end
			end
			scm_pkg::ST_WAIT_D, scm_pkg::ST_WAIT_LIT,
			scm_pkg::ST_WAIT_W: begin
				if (i_mem_ack) begin
					nxt_state = last_slot ? scm_pkg::ST_FETCH :
						scm_pkg::ST_EXEC;
				end
			end
			default: nxt_state = scm_pkg::ST_FETCH;
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_ff <= scm_pkg::ST_FETCH;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Slots run from the high field down; the word is refetched after slot 3.
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			instr_ff <= scm_pkg::RST_WORD;
			slot_ff <= scm_pkg::RST_SLOT;
		end else if ((state_ff == scm_pkg::ST_WAIT_I) && i_mem_ack) begin
			instr_ff <= i_mem_rdata;
			slot_ff <= scm_pkg::RST_SLOT; // (RQ18)
		end else if (nxt_state == scm_pkg::ST_EXEC) begin
			slot_ff <= slot_ff + 2'h1; // (RQ18)
		end
	end

	// ----------------------------------------------------------------
	// Program counter
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pc_ff <= scm_pkg::RST_PC;
		end else if (((state_ff == scm_pkg::ST_WAIT_I) && i_mem_ack) ||
			lit_done) begin
			pc_ff <= pc_ff + scm_pkg::ADDR_STEP; // (RQ3)
		end
	end

	// ----------------------------------------------------------------
	// Memory port
	// ----------------------------------------------------------------
	// Address and data are held in flops so memory may take any time to ack.
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			req_ff <= 1'b0;
			we_ff <= 1'b0;
			maddr_ff <= scm_pkg::RST_WORD;
			wdata_ff <= scm_pkg::RST_WORD;
		end else if (req_ff) begin
			if (i_mem_ack) begin
				req_ff <= 1'b0;
				we_ff <= 1'b0;
			end
		end else if ((state_ff == scm_pkg::ST_FETCH) && i_run) begin
			req_ff <= 1'b1;
			maddr_ff <= pc_ff;
		end else if (exec && is_read(cur_op)) begin
			req_ff <= 1'b1;
			maddr_ff <= addr_ff; // (RQ1) (RQ4)
		end else if (exec && (cur_op == scm_pkg::OP_LITERAL)) begin
			req_ff <= 1'b1;
			maddr_ff <= pc_ff; // (RQ3)
		end else if (exec && is_write(cur_op)) begin
			req_ff <= 1'b1;
			we_ff <= 1'b1;
			maddr_ff <= addr_ff; // (RQ5) (RQ6)
			wdata_ff <= top_ff;
		end
	end

	// ----------------------------------------------------------------
	// Address register
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			addr_ff <= scm_pkg::RST_WORD;
		end else if (rd_done && (cur_op == scm_pkg::OP_FETCH_ADVANCE)) begin
			addr_ff <= addr_ff + scm_pkg::ADDR_STEP; // (RQ1)
		end else if (exec) begin
			case (cur_op)
				scm_pkg::OP_WRITE_ADVANCE: begin
					addr_ff <= addr_ff + scm_pkg::ADDR_STEP; // (RQ5)
				end
				scm_pkg::OP_MUL_STEP: begin
					addr_ff <= {mul_sum[0], addr_ff[23:1]}; // (RQ13) (RQ14)
				end
				scm_pkg::OP_DIV_STEP: begin
					addr_ff <= {addr_ff[22:0], div_sum[24]}; // (RQ17)
				end
				default: addr_ff <= addr_ff;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Top of stack and carry
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			top_ff <= scm_pkg::RST_WORD;
		end else if (push_en) begin
			top_ff <= i_mem_rdata; // (RQ1) (RQ3) (RQ4)
		end else if (exec) begin
			case (cur_op)
				scm_pkg::OP_WRITE_ADVANCE, scm_pkg::OP_WRITE_HOLD: begin
					top_ff <= second_ff; // (RQ5) (RQ6)
				end
				scm_pkg::OP_BYTE_ROTATE: begin
					top_ff <= {top_ff[7:0], top_ff[23:8]}; // (RQ7)
				end
				scm_pkg::OP_INVERT: top_ff <= ~top_ff; // (RQ9)
				scm_pkg::OP_SHIFT_LEFT: begin
					top_ff <= {top_ff[22:0], 1'b0}; // (RQ10)
				end
				scm_pkg::OP_SHIFT_RIGHT: begin
					top_ff <= {top_ff[23], top_ff[23:1]}; // (RQ11)
				end
				scm_pkg::OP_MUL_STEP: top_ff <= mul_sum[24:1]; // (RQ13) (RQ14)
				scm_pkg::OP_XOR: top_ff <= top_ff ^ second_ff; // (RQ15)
				scm_pkg::OP_AND: top_ff <= top_ff & second_ff; // (RQ16)
				scm_pkg::OP_DIV_STEP: begin
					top_ff <= {div_keep[22:0], addr_ff[23]}; // (RQ17)
				end
				default: top_ff <= top_ff;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			carry_ff <= 1'b0;
		end else if (push_en) begin
			carry_ff <= 1'b0; // (RQ2) (RQ19)
		end else if (exec && (cur_op == scm_pkg::OP_SHIFT_LEFT)) begin
			carry_ff <= top_ff[23]; // (RQ10) (RQ19)
		end else if (exec && (cur_op == scm_pkg::OP_SHIFT_RIGHT)) begin
			carry_ff <= i_ser_in; // (RQ12)
		end
	end

	// ----------------------------------------------------------------
	// Serial output
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ser_out_ff <= 1'b0;
		end else if (exec && (cur_op == scm_pkg::OP_SHIFT_RIGHT)) begin
			ser_out_ff <= top_ff[0]; // (RQ11)
		end
	end

	// ----------------------------------------------------------------
	// Second of stack and deeper stack
	// ----------------------------------------------------------------
	// The deeper stack is circular: overflow overwrites the oldest entry
	// and underflow rereads stale data rather than stalling the core.
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			second_ff <= scm_pkg::RST_WORD;
			ptr_ff <= scm_pkg::RST_PTR;
		end else if (push_en) begin
			second_ff <= top_ff; // (RQ20)
			ptr_ff <= ptr_up;
		end else if (pop_en) begin
			second_ff <= stk_ff[ptr_ff]; // (RQ8) (RQ20)
			ptr_ff <= (ptr_ff == scm_pkg::RST_PTR) ? scm_pkg::LAST_PTR :
				ptr_ff - 4'h1;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			for (int i = 0; i < STACK_DEPTH; i++) begin
				stk_ff[i] <= scm_pkg::RST_WORD;
			end
		end else if (push_en) begin
			stk_ff[ptr_up] <= second_ff; // (RQ20)
		end
	end

	// Depth counts live entries beyond top and second, saturating.
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			depth_ff <= scm_pkg::RST_PTR;
		end else if (push_en && (depth_ff != scm_pkg::LAST_PTR + 4'h1)) begin
			depth_ff <= depth_ff + 4'h1;
		end else if (pop_en && (depth_ff != scm_pkg::RST_PTR)) begin
			depth_ff <= depth_ff - 4'h1;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign o_mem_req = req_ff;
	assign o_mem_we = we_ff;
	assign o_mem_addr = maddr_ff;
	assign o_mem_wdata = wdata_ff;
	assign o_ser_out = ser_out_ff;
	assign o_top = top_ff;
	assign o_second = second_ff;
	assign o_addr = addr_ff;
	assign o_pc = pc_ff;
	assign o_carry = carry_ff;
	assign o_depth = depth_ff;

endmodule

// file: scm_core_checker.sv
// Concurrent checks on the memory port and stack outputs of the core.
`timescale 1ns/1ps
module scm_core_checker (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic i_ser_in,
	input wire logic i_mem_ack,
	input wire logic [23:0] i_mem_rdata,
	input wire logic o_mem_req,
	input wire logic o_mem_we,
	input wire logic [23:0] o_mem_addr,
	input wire logic [23:0] o_mem_wdata,
	input wire logic o_ser_out,
	input wire logic [23:0] o_top,
	input wire logic [23:0] o_second,
	input wire logic [23:0] o_addr,
	input wire logic [23:0] o_pc,
	input wire logic o_carry,
	input wire logic [3:0] o_depth
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);
	// Reads are told apart by address alone, so a read whose address equals
	// both the program counter and the address register is left unchecked.
	logic rd_done;
	logic pc_done;
	assign rd_done = o_mem_req && i_mem_ack && !o_mem_we &&
		o_mem_addr == o_addr && o_mem_addr != o_pc;
	assign pc_done = o_mem_req && i_mem_ack && !o_mem_we &&
		o_mem_addr == o_pc && o_mem_addr != o_addr;
	property p_wr_pop;
		$rose(o_mem_req) && o_mem_we |-> o_mem_wdata == $past(o_top) &&
			o_mem_addr == $past(o_addr) && o_top == $past(o_second);
	endproperty
	a_wr_pop: assert property (p_wr_pop) else $error("bad write pop");
	property p_wr_step;
		$rose(o_mem_req) && o_mem_we |->
			o_addr == $past(o_addr) || o_addr == $past(o_addr) + 24'h000001;
	endproperty
	a_wr_step: assert property (p_wr_step) else $error("bad write step");
	property p_rd_push;
		rd_done |=> o_top == $past(i_mem_rdata) && o_second == $past(o_top) &&
			!o_carry;
	endproperty
	a_rd_push: assert property (p_rd_push) else $error("bad fetch push");
	property p_rd_step;
		rd_done |=>
			o_addr == $past(o_addr) || o_addr == $past(o_addr) + 24'h000001;
	endproperty
	a_rd_step: assert property (p_rd_step) else $error("bad fetch step");
	property p_pc_step;
		pc_done |=> o_pc == $past(o_pc) + 24'h000001;
	endproperty
	a_pc_step: assert property (p_pc_step) else $error("bad pc step");
	property p_ser;
		$changed(o_ser_out) |-> o_ser_out == $past(o_top[0]) &&
			o_top[23] == $past(o_top[23]);
	endproperty
	a_ser: assert property (p_ser) else $error("bad serial out");
	property p_carry;
		$changed(o_carry) |-> !o_carry || o_carry == $past(i_ser_in) ||
			o_carry == $past(o_top[23]) && !o_top[0];
	endproperty
	a_carry: assert property (p_carry) else $error("bad carry");
	property p_depth;
		$changed(o_depth) |-> o_depth == $past(o_depth) + 4'h1 ||
			o_depth == $past(o_depth) - 4'h1;
	endproperty
	a_depth: assert property (p_depth) else $error("bad depth step");
	c_write: cover property ($rose(o_mem_req) && o_mem_we);
	c_read: cover property (rd_done);
	c_ser: cover property ($changed(o_ser_out));
endmodule

bind scm_core scm_core_checker u_scm_chk (.i_sys_clk, .i_rstn, .i_ser_in,
	.i_mem_ack, .i_mem_rdata, .o_mem_req, .o_mem_we, .o_mem_addr,
	.o_mem_wdata, .o_ser_out, .o_top, .o_second, .o_addr, .o_pc, .o_carry,
	.o_depth);

// file: scm_mem_model.sv
// Behavioural program and data memory on the core's request port.
`timescale 1ns/1ps
module scm_mem_model (
	input wire logic i_sys_clk,
	input wire logic i_req,
	input wire logic i_we,
	input wire logic [23:0] i_addr,
	input wire logic [23:0] i_wdata,
	output logic o_ack,
	output logic [23:0] o_rdata
);
	logic [23:0] mem[logic [23:0]];
	logic [1:0] wait_ff = 2'h0;
	logic [1:0] lat_ff = 2'h0;
	initial o_ack = 1'b0;
	initial o_rdata = 24'h000000;
	// Latency walks through one to four cycles, so prompt and slow answers
	// both occur; read data toggles outside the answer cycle.
	always @(posedge i_sys_clk) begin
		o_ack <= 1'b0;
		o_rdata <= ~o_rdata;
		if (i_req && !o_ack && wait_ff == 2'h0) begin
			o_ack <= 1'b1;
			o_rdata <= mem.exists(i_addr) ? mem[i_addr] : 24'h000000;
			if (i_we) mem[i_addr] = i_wdata;
			lat_ff <= lat_ff + 2'h1;
			wait_ff <= lat_ff;
		end else if (i_req && !o_ack) begin
			wait_ff <= wait_ff - 2'h1;
		end
	end
endmodule

// file: scm_pkg.sv
// Shared constants and types for the stack machine memory and ALU datapath.
package scm_pkg;

	// ----------------------------------------------------------------
	// Widths and geometry
	// ----------------------------------------------------------------
	localparam int DATA_W = 24;
	localparam int OP_W = 6;
	localparam int SLOT_CNT = 4;
	localparam int SLOT_W = 2;
	localparam int ROT_BITS = 8;
	localparam int STACK_DEPTH = 15;
	localparam int PTR_W = 4;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [23:0] RST_WORD = 24'h000000;
	localparam logic [23:0] RST_PC = 24'h000000;
	localparam logic [1:0] RST_SLOT = 2'h0;
	localparam logic [1:0] LAST_SLOT = 2'h3;
	localparam logic [3:0] RST_PTR = 4'h0;
	localparam logic [3:0] LAST_PTR = 4'hE;
	localparam logic [23:0] ADDR_STEP = 24'h000001;

	// ----------------------------------------------------------------
	// Opcodes handled by this datapath
	// ----------------------------------------------------------------
	localparam logic [5:0] OP_BYTE_ROTATE = 6'h08;
	localparam logic [5:0] OP_FETCH_ADVANCE = 6'h09;
	localparam logic [5:0] OP_LITERAL = 6'h0A;
	localparam logic [5:0] OP_FETCH_HOLD = 6'h0B;
	localparam logic [5:0] OP_DROP_SECOND = 6'h0C;
	localparam logic [5:0] OP_WRITE_ADVANCE = 6'h0D;
	localparam logic [5:0] OP_WRITE_HOLD = 6'h0F;
	localparam logic [5:0] OP_INVERT = 6'h10;
	localparam logic [5:0] OP_SHIFT_LEFT = 6'h11;
	localparam logic [5:0] OP_SHIFT_RIGHT = 6'h12;
	localparam logic [5:0] OP_MUL_STEP = 6'h13;
	localparam logic [5:0] OP_XOR = 6'h14;
	localparam logic [5:0] OP_AND = 6'h15;
	localparam logic [5:0] OP_DIV_STEP = 6'h16;

	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [5:0] {
		ST_FETCH = 6'h01,
		ST_WAIT_I = 6'h02,
		ST_EXEC = 6'h04,
		ST_WAIT_D = 6'h08,
		ST_WAIT_LIT = 6'h10,
		ST_WAIT_W = 6'h20
	} scm_state_type;

endpackage

// file: tb_scm_core.sv
// Random program run on the core against a reference machine.
`timescale 1ns/1ps
module tb_scm_core;
	typedef struct {
		logic we, chk, c, so, ser;
		logic [23:0] addr, wdata, t, s, a;
		logic [3:0] d;
	} scm_note_type;
	logic i_sys_clk, i_rstn, i_run, i_ser_in, i_mem_ack;
	logic o_mem_req, o_mem_we, o_ser_out, o_carry;
	logic [23:0] i_mem_rdata, o_mem_addr, o_mem_wdata;
	logic [23:0] o_top, o_second, o_addr, o_pc;
	logic [3:0] o_depth;
	int failures = 0;
	int samples_checked = 0;
	int cycles = 0;
	logic [31:0] seed = 32'h0000005A;
	scm_note_type notes[$];
	scm_note_type n;
	logic [23:0] t, s, a, pc;
	logic c, so;
	logic [23:0] stk[$];
	logic [23:0] rmem[logic [23:0]];
	logic [5:0] ops[$];
	logic [23:0] lits[$];

	scm_core DUT (.i_sys_clk, .i_rstn, .i_run, .i_ser_in, .i_mem_ack,
		.i_mem_rdata, .o_mem_req, .o_mem_we, .o_mem_addr, .o_mem_wdata,
		.o_ser_out, .o_top, .o_second, .o_addr, .o_pc, .o_carry, .o_depth);
	scm_mem_model MEM (.i_sys_clk, .i_req(o_mem_req), .i_we(o_mem_we),
		.i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .o_ack(i_mem_ack),
		.o_rdata(i_mem_rdata));

	initial begin
		i_sys_clk = 1'b0;
		forever #2 i_sys_clk = ~i_sys_clk;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [23:0] rd(logic [23:0] ad);
		return rmem.exists(ad) ? rmem[ad] : 24'h000000;
	endfunction
	task automatic check(string nm, logic [23:0] seen, logic [23:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wrap_up();
		if (failures == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ----------------
	// Reference machine
	// ----------------
	task automatic note(logic we, chk, ser, logic [23:0] ad, wd);
		notes.push_back(scm_note_type'{we, chk, c, so, ser, ad, wd, t, s, a,
			4'(stk.size())});
	endtask
	task automatic push(logic [23:0] v);
		stk.push_back(s);
		s = t;
		t = v;
		c = 1'b0;
	endtask
	task automatic pops();
		s = stk.pop_back();
	endtask
	task automatic add(logic [5:0] op, logic [23:0] lit);
		ops.push_back(op);
		lits.push_back(lit);
	endtask
	task automatic run_word();
		logic [23:0] w;
		logic [23:0] v;
		logic [24:0] sum;
		logic ser;
		v = 24'(rnd());
		ser = v[0];
		note(1'b0, 1'b1, ser, pc, 24'h000000);
		w = rd(pc);
		pc++;
		for (int k = 3; k >= 0; k--) begin
			case (w[k * 6 +: 6])
			scm_pkg::OP_BYTE_ROTATE: t = {t[7:0], t[23:8]};
			scm_pkg::OP_FETCH_ADVANCE, scm_pkg::OP_FETCH_HOLD: begin
				note(1'b0, 1'b0, 1'b0, a, 24'h000000);
				push(rd(a));
				if (!w[k * 6 + 1]) a++;
			end
			scm_pkg::OP_LITERAL: begin
				note(1'b0, 1'b0, 1'b0, pc, 24'h000000);
				push(rd(pc));
				pc++;
			end
			scm_pkg::OP_DROP_SECOND: pops();
			scm_pkg::OP_WRITE_ADVANCE, scm_pkg::OP_WRITE_HOLD: begin
				note(1'b1, 1'b0, 1'b0, a, t);
				rmem[a] = t;
				t = s;
				pops();
				if (!w[k * 6 + 1]) a++;
			end
			scm_pkg::OP_INVERT: t = ~t;
			scm_pkg::OP_SHIFT_LEFT: {c, t} = {t, 1'b0};
			scm_pkg::OP_SHIFT_RIGHT: {so, c, t} = {t[0], ser, t[23], t[23:1]};
			scm_pkg::OP_MUL_STEP: begin
				sum = a[0] ? {1'b0, t} + s : {1'b0, t};
				{t, a} = {sum, a[23:1]};
			end
			scm_pkg::OP_XOR: {t, s} = {t ^ s, stk.pop_back()};
			scm_pkg::OP_AND: {t, s} = {t & s, stk.pop_back()};
			scm_pkg::OP_DIV_STEP: begin
				sum = {1'b0, t} + s;
				v = sum[24] ? sum[23:0] : t;
				{t, a} = {v[22:0], a, sum[24]};
			end
			default: ;
			endcase
		end
	endtask

	always @(posedge i_sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			wrap_up();
		end
	end
	always @(posedge i_sys_clk) begin
		if (i_rstn && o_mem_req && i_mem_ack) begin
			if (notes.size() == 0) begin
				check("extra_request", 24'h000001, 24'h000000);
			end else begin
				n = notes.pop_front();
				check("mem_we", 24'(o_mem_we), 24'(n.we));
				check("mem_addr", o_mem_addr, n.addr);
				if (n.we) check("mem_wdata", o_mem_wdata, n.wdata);
				if (n.chk) begin
					check("top", o_top, n.t);
					check("second", o_second, n.s);
					check("addr", o_addr, n.a);
					check("carry", 24'(o_carry), 24'(n.c));
					check("ser_out", 24'(o_ser_out), 24'(n.so));
					check("depth", 24'(o_depth), 24'(n.d));
					check("pc", o_pc, n.addr);
					i_ser_in <= n.ser;
				end
				if (notes.size() == 0) i_run <= 1'b0;
			end
		end
	end

	initial begin
		int p;
		int dd;
		logic [5:0] op;
		logic [23:0] w;
		logic [47:0] prod;
		i_rstn = 1'b0;
		i_run = 1'b0;
		i_ser_in = 1'b0;
		{t, s, a, pc, c, so} = '0;
		add(scm_pkg::OP_LITERAL, 24'(rnd()));
		repeat (24) add(scm_pkg::OP_MUL_STEP, 24'h000000);
		add(scm_pkg::OP_LITERAL, 24'(rnd()));
		add(scm_pkg::OP_LITERAL, 24'h000000);
		repeat (24) add(scm_pkg::OP_MUL_STEP, 24'h000000);
		add(6'h00, 24'h000000);
		dd = 3;
		// Depth stays in 0..15 so that no stale stack entry is ever seen.
		repeat (200) begin
			op = 6'(8 + rnd() % 15);
			if (dd == 0 && op inside {6'h0C, 6'h0D, 6'h0F, 6'h14, 6'h15} ||
				dd == 15 && op inside {[6'h09:6'h0B]})
				op = scm_pkg::OP_INVERT;
			dd += int'(op inside {[6'h09:6'h0B]});
			dd -= int'(op inside {6'h0C, 6'h0D, 6'h0F, 6'h14, 6'h15});
			add(op, 24'(rnd()));
		end
		p = 0;
		for (int i = 0; i < ops.size(); i += 4) begin
			w = 24'h000000;
			for (int k = i; k < i + 4; k++)
				w = {w[17:0], k < ops.size() ? ops[k] : 6'h00};
			rmem[24'(p)] = w;
			p++;
			for (int k = i; k < i + 4 && k < ops.size(); k++)
				if (ops[k] == scm_pkg::OP_LITERAL) begin
					rmem[24'(p)] = lits[k];
					p++;
				end
		end
		foreach (rmem[k]) MEM.mem[k] = rmem[k];
		prod = 48'(lits[0]) * 48'(lits[25]);
		while (pc < 24'(p)) begin
			run_word();
			if (pc == 24'h000010) begin
				check("product_high", t, prod[47:24]);
				check("product_low", a, prod[23:0]);
				check("multiplicand", s, lits[25]);
			end
		end
		note(1'b0, 1'b1, 1'b0, pc, 24'h000000);
		repeat (5) @(posedge i_sys_clk);
		i_rstn <= 1'b1;
		i_run <= 1'b1;
		while (notes.size() > 0) @(posedge i_sys_clk);
		repeat (40) @(posedge i_sys_clk);
		wrap_up();
	end
endmodule
